// >>> logic/chs_status_bank.sv
// How it works
// - Charge phase in bits 7-5 of first register, codes 0 to 4.
// - Phase reads 6 top-off, 7 terminated; code 5 never reported.
// - Input source in bits 4-1, codes 1 to 6 for detected ports.
// - Source 7 reverse, 8 unqualified, B bus, C backup; others reserved.
// - Source reads 0 with no input or reverse-mode hot/cold fault.
// - Bit 0 of first register shows port detection complete.
// - Optimizer state in bits 7-6 of second register; code 3 reserved.
// - Bit 2 of second register shows thermal regulation.
// - Bit 1 of second register set only while data-line detection runs.
// - Bit 0 of second register shows battery present.
// - Bits 7 and 6 of third register show blocking pairs fitted.
// - Bit 5 of third register flags one-shot conversion complete.
// - Bit 4 set in forward mode while system held at minimum.
// - Bit 3 of third register shows fast-charge timer expired.
// - Bit 2 of third register shows trickle timer expired.
// - Bit 1 of third register shows pre-charge timer expired.
// - All registers read-only and zero after reset.
//
// Chosen here: register access over AHB-Lite.
`include "chs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module chs_status_bank (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire chs_pkg::chs_status_in_type status_raw_in,
  output logic [7:0] status_one,
  output logic [7:0] status_two,
  output logic [7:0] status_three
);

  // ----------------------------------------
  // Decoding functions
  // ----------------------------------------

  // Maps a byte address onto one of the three registers.
  function automatic chs_pkg::chs_sel_type reg_sel(input logic [31:0] a);
    chs_pkg::chs_sel_type s;
    s = chs_pkg::CHS_SEL_NONE;
    if (a[1:0] == `CHS_LANE_ZERO) begin
      if (a[31:`CHS_ADDR_SHIFT] == `CHS_IDX_ONE) begin
        s = chs_pkg::CHS_SEL_ONE;
      end else if (a[31:`CHS_ADDR_SHIFT] == `CHS_IDX_TWO) begin
        s = chs_pkg::CHS_SEL_TWO;
      end else if (a[31:`CHS_ADDR_SHIFT] == `CHS_IDX_THREE) begin
        s = chs_pkg::CHS_SEL_THREE;
      end
    end
    return s;
  endfunction : reg_sel

  // True for input source codes that are never reported.
  function automatic logic src_reserved(input logic [3:0] c);
    return (c == `CHS_SRC_RSVD_9) || (c == `CHS_SRC_RSVD_A) || (c >= `CHS_SRC_RSVD_LO);
  endfunction : src_reserved

  // ----------------------------------------
  // State and bus decode
  // ----------------------------------------

  chs_pkg::chs_state_type st_r;
  chs_pkg::chs_state_type st_nxt;
  chs_pkg::chs_status_in_type cur;
  chs_pkg::chs_sel_type sel;
  logic accept;
  logic rd_accept;
  logic rd_three;
  logic rev_fault;
  logic done_pulse;

  // A transfer is taken only on an enabled cycle with hready high.
  assign accept = hsel && htrans[1] && hready && clk_en;
  assign rd_accept = accept && !hwrite;
  assign sel = reg_sel(haddr);
  assign rd_three = rd_accept && (sel == chs_pkg::CHS_SEL_THREE);

  // The synchronised status levels feed every register.
  assign cur = st_r.sync2;
  assign rev_fault = (cur.input_source_type == `CHS_SRC_REVERSE) &&
                     (cur.reverse_mode_hot_fault || cur.reverse_mode_cold_fault);
  assign done_pulse = cur.conversion_done && !st_r.done_prev && cur.oneshot_mode;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------

  // Fills the next state; nothing moves while the clock enable is low.
  always_comb begin
    st_nxt = st_r;
    if (clk_en) begin
      st_nxt.sync1 = status_raw_in;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.done_prev = cur.conversion_done;

      if (cur.charge_phase != `CHS_PHASE_RSVD) begin
        st_nxt.stat_one[`CHS_PHASE_HI:`CHS_PHASE_LO] = cur.charge_phase;
      end

      if (rev_fault) begin
        st_nxt.stat_one[`CHS_SRC_HI:`CHS_SRC_LO] = `CHS_SRC_NONE;
      end else if (!src_reserved(cur.input_source_type)) begin
        st_nxt.stat_one[`CHS_SRC_HI:`CHS_SRC_LO] = cur.input_source_type;
      end

      st_nxt.stat_one[`CHS_DET_BIT] = cur.port_detect_complete;

      if (cur.current_optimizer_state != `CHS_OPT_RSVD) begin
        st_nxt.stat_two[`CHS_OPT_HI:`CHS_OPT_LO] = cur.current_optimizer_state;
      end

      st_nxt.stat_two[`CHS_RSV2_HI:`CHS_RSV2_LO] = '0;
      st_nxt.stat_three[`CHS_RSV3_BIT] = 1'b0;

      st_nxt.stat_two[`CHS_TREG_BIT] = cur.thermal_regulation_flag;
      st_nxt.stat_two[`CHS_DPDM_BIT] = cur.data_line_detect_running;
      st_nxt.stat_two[`CHS_BAT_BIT] = cur.battery_undervoltage_release;

      st_nxt.stat_three[`CHS_PAIR2_BIT] = cur.blocking_pair_two_fitted;
      st_nxt.stat_three[`CHS_PAIR1_BIT] = cur.blocking_pair_one_fitted;

      // One-shot completion flag.
      // A read clears it, a new completion in the same cycle wins, and it
      // reads zero whenever the converter is not in one-shot mode.
      if (!cur.oneshot_mode) begin
        st_nxt.stat_three[`CHS_DONE_BIT] = 1'b0;
      end else if (done_pulse) begin
        st_nxt.stat_three[`CHS_DONE_BIT] = 1'b1;
      end else if (rd_three) begin
        st_nxt.stat_three[`CHS_DONE_BIT] = 1'b0;
      end

      st_nxt.stat_three[`CHS_MINSYS_BIT] = cur.forward_mode && cur.sys_held_at_min;
      st_nxt.stat_three[`CHS_FAST_BIT] = cur.fast_charge_timer_expired;
      st_nxt.stat_three[`CHS_TRICKLE_BIT] = cur.trickle_timer_expired;
      st_nxt.stat_three[`CHS_PRE_BIT] = cur.precharge_timer_expired;

      // Reads only; writes ignored.
      // The read word is latched at the address phase and shown in the
      // data phase; unmapped addresses read as zero.
      if (rd_accept) begin
        unique case (sel)
          chs_pkg::CHS_SEL_ONE: st_nxt.hrdata = {`CHS_PAD_ZERO, st_r.stat_one};
          chs_pkg::CHS_SEL_TWO: st_nxt.hrdata = {`CHS_PAD_ZERO, st_r.stat_two};
          chs_pkg::CHS_SEL_THREE: st_nxt.hrdata = {`CHS_PAD_ZERO, st_r.stat_three};
          chs_pkg::CHS_SEL_NONE: st_nxt.hrdata = `CHS_RDATA_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Zero wait states; a frozen clock enable stretches the transfer.
  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign hrdata = st_r.hrdata;
  assign status_one = st_r.stat_one;
  assign status_two = st_r.stat_two;
  assign status_three = st_r.stat_three;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Three enabled edges carry a pin level into a register.
  sequence s_ce3;
    clk_en [*3] ##1 1'b1;
  endsequence

  // A read address phase is taken.
  sequence s_rd(chs_pkg::chs_sel_type s);
    rd_accept && (sel == s);
  endsequence

  property p_phase_track;
    (s_ce3 ##0 ($past(status_raw_in.charge_phase, 3) != `CHS_PHASE_RSVD)) |->
      (st_r.stat_one[`CHS_PHASE_HI:`CHS_PHASE_LO] == $past(status_raw_in.charge_phase, 3));
  endproperty
  a_phase_track: assert property (p_phase_track) else $error("Phase field lost.");

  property p_phase_rsvd;
    st_r.stat_one[`CHS_PHASE_HI:`CHS_PHASE_LO] != `CHS_PHASE_RSVD;
  endproperty
  a_phase_rsvd: assert property (p_phase_rsvd) else $error("Reserved phase shown.");

  property p_src_track;
    (clk_en && !rev_fault && !src_reserved(cur.input_source_type)) |=>
      (st_r.stat_one[`CHS_SRC_HI:`CHS_SRC_LO] == $past(cur.input_source_type));
  endproperty
  a_src_track: assert property (p_src_track) else $error("Source field lost.");

  property p_src_rsvd;
    !src_reserved(st_r.stat_one[`CHS_SRC_HI:`CHS_SRC_LO]);
  endproperty
  a_src_rsvd: assert property (p_src_rsvd) else $error("Reserved source shown.");

  property p_src_fault;
    (clk_en && rev_fault) |=> (st_r.stat_one[`CHS_SRC_HI:`CHS_SRC_LO] == `CHS_SRC_NONE);
  endproperty
  a_src_fault: assert property (p_src_fault) else $error("Fault not forcing zero.");

  property p_detect;
    s_ce3 |-> (st_r.stat_one[`CHS_DET_BIT] == $past(status_raw_in.port_detect_complete, 3));
  endproperty
  a_detect: assert property (p_detect) else $error("Detect flag wrong.");

  property p_opt_rsvd;
    st_r.stat_two[`CHS_OPT_HI:`CHS_OPT_LO] != `CHS_OPT_RSVD;
  endproperty
  a_opt_rsvd: assert property (p_opt_rsvd) else $error("Reserved optimizer state.");

  property p_thermal;
    s_ce3 |-> (st_r.stat_two[`CHS_TREG_BIT] == $past(status_raw_in.thermal_regulation_flag, 3));
  endproperty
  a_thermal: assert property (p_thermal) else $error("Thermal flag wrong.");

  property p_dpdm;
    s_ce3 |-> (st_r.stat_two[`CHS_DPDM_BIT] == $past(status_raw_in.data_line_detect_running, 3));
  endproperty
  a_dpdm: assert property (p_dpdm) else $error("Detect running flag wrong.");

  property p_battery;
    s_ce3 |-> (st_r.stat_two[`CHS_BAT_BIT] == $past(status_raw_in.battery_undervoltage_release, 3));
  endproperty
  a_battery: assert property (p_battery) else $error("Battery flag wrong.");

  property p_pairs;
    s_ce3 |-> (st_r.stat_three[`CHS_PAIR2_BIT] == $past(status_raw_in.blocking_pair_two_fitted, 3)) &&
              (st_r.stat_three[`CHS_PAIR1_BIT] == $past(status_raw_in.blocking_pair_one_fitted, 3));
  endproperty
  a_pairs: assert property (p_pairs) else $error("Pair flags wrong.");

  property p_done_set;
    (clk_en && done_pulse) |=> st_r.stat_three[`CHS_DONE_BIT];
  endproperty
  a_done_set: assert property (p_done_set) else $error("Completion lost.");

  property p_done_mode;
    (clk_en && !cur.oneshot_mode) |=> !st_r.stat_three[`CHS_DONE_BIT];
  endproperty
  a_done_mode: assert property (p_done_mode) else $error("Completion outside one-shot.");

  property p_minsys;
    clk_en |=> (st_r.stat_three[`CHS_MINSYS_BIT] == ($past(cur.forward_mode) && $past(cur.sys_held_at_min)));
  endproperty
  a_minsys: assert property (p_minsys) else $error("Minimum system flag wrong.");

  property p_fast;
    s_ce3 |-> (st_r.stat_three[`CHS_FAST_BIT] == $past(status_raw_in.fast_charge_timer_expired, 3));
  endproperty
  a_fast: assert property (p_fast) else $error("Fast timer flag wrong.");

  property p_trickle;
    s_ce3 |-> (st_r.stat_three[`CHS_TRICKLE_BIT] == $past(status_raw_in.trickle_timer_expired, 3));
  endproperty
  a_trickle: assert property (p_trickle) else $error("Trickle timer flag wrong.");

  property p_pre;
    s_ce3 |-> (st_r.stat_three[`CHS_PRE_BIT] == $past(status_raw_in.precharge_timer_expired, 3));
  endproperty
  a_pre: assert property (p_pre) else $error("Pre-charge timer flag wrong.");

  property p_read_two;
    s_rd(chs_pkg::CHS_SEL_TWO) |=> (hrdata == {`CHS_PAD_ZERO, $past(st_r.stat_two)}) && (hreadyout == clk_en) ##0 !hresp;
  endproperty
  a_read_two: assert property (p_read_two) else $error("Read data wrong.");

  property p_reserved;
    (st_r.stat_two[`CHS_RSV2_HI:`CHS_RSV2_LO] == '0) && !st_r.stat_three[`CHS_RSV3_BIT] &&
    (hrdata[31:8] == `CHS_PAD_ZERO);
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bits set.");

  // A low clock enable holds every flop, synchronisers included.
  property p_freeze;
    !clk_en |=> $stable(st_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved while frozen.");

  property p_phase_hold;
    (clk_en && (cur.charge_phase == `CHS_PHASE_RSVD)) |=>
      $stable(st_r.stat_one[`CHS_PHASE_HI:`CHS_PHASE_LO]);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("Reserved phase loaded.");

  property p_src_hold;
    (clk_en && !rev_fault && src_reserved(cur.input_source_type)) |=>
      $stable(st_r.stat_one[`CHS_SRC_HI:`CHS_SRC_LO]);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("Reserved source loaded.");

  property p_opt_track;
    (clk_en && (cur.current_optimizer_state != `CHS_OPT_RSVD)) |=>
      (st_r.stat_two[`CHS_OPT_HI:`CHS_OPT_LO] == $past(cur.current_optimizer_state));
  endproperty
  a_opt_track: assert property (p_opt_track) else $error("Optimizer field lost.");

  // A read of the third register with no new completion behind it.
  sequence s_done_read;
    s_rd(chs_pkg::CHS_SEL_THREE) ##0 !done_pulse;
  endsequence

  property p_done_clear;
    s_done_read |=> !st_r.stat_three[`CHS_DONE_BIT];
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("Completion not cleared.");

  property p_read_one;
    s_rd(chs_pkg::CHS_SEL_ONE) |=> (hrdata == {`CHS_PAD_ZERO, $past(st_r.stat_one)});
  endproperty
  a_read_one: assert property (p_read_one) else $error("First read data wrong.");

  property p_read_three;
    s_rd(chs_pkg::CHS_SEL_THREE) |=> (hrdata == {`CHS_PAD_ZERO, $past(st_r.stat_three)});
  endproperty
  a_read_three: assert property (p_read_three) else $error("Third read data wrong.");

  property p_read_none;
    s_rd(chs_pkg::CHS_SEL_NONE) |=> (hrdata == `CHS_RDATA_ZERO);
  endproperty
  a_read_none: assert property (p_read_none) else $error("Unmapped read not zero.");

  property p_hold_rdata;
    !rd_accept |=> $stable(hrdata);
  endproperty
  a_hold_rdata: assert property (p_hold_rdata) else $error("Read data moved without a read.");

endmodule : chs_status_bank
`default_nettype wire

// >>> logic/chs_params.svh
`ifndef CHS_PARAMS_SVH
`define CHS_PARAMS_SVH
// Register indices; the byte address is the index shifted left by two.
`define CHS_IDX_ONE 30'h0000_001C
`define CHS_IDX_TWO 30'h0000_001D
`define CHS_IDX_THREE 30'h0000_001E
`define CHS_ADDR_SHIFT 2
`define CHS_LANE_ZERO 2'h0
// Reset and padding values.
`define CHS_RST_BYTE 8'h00
`define CHS_PAD_ZERO 24'h00_0000
`define CHS_RDATA_ZERO 32'h0000_0000
// Field positions of the first status register.
`define CHS_PHASE_HI 7
`define CHS_PHASE_LO 5
`define CHS_SRC_HI 4
`define CHS_SRC_LO 1
`define CHS_DET_BIT 0
// Field positions of the second status register.
`define CHS_OPT_HI 7
`define CHS_OPT_LO 6
`define CHS_RSV2_HI 5
`define CHS_RSV2_LO 3
`define CHS_TREG_BIT 2
`define CHS_DPDM_BIT 1
`define CHS_BAT_BIT 0
// Field positions of the third status register.
`define CHS_PAIR2_BIT 7
`define CHS_PAIR1_BIT 6
`define CHS_DONE_BIT 5
`define CHS_MINSYS_BIT 4
`define CHS_FAST_BIT 3
`define CHS_TRICKLE_BIT 2
`define CHS_PRE_BIT 1
`define CHS_RSV3_BIT 0
// Codes that are reserved or forced.
`define CHS_PHASE_RSVD 3'h5
`define CHS_SRC_NONE 4'h0
`define CHS_SRC_REVERSE 4'h7
`define CHS_SRC_RSVD_9 4'h9
`define CHS_SRC_RSVD_A 4'hA
`define CHS_SRC_RSVD_LO 4'hD
`define CHS_OPT_RSVD 2'h3
`endif

// >>> logic/chs_pkg.sv
`default_nettype none
package chs_pkg;

  // Status levels arriving from the charger core.
  typedef struct packed {
    logic [2:0] charge_phase;
    logic [3:0] input_source_type;
    logic port_detect_complete;
    logic [1:0] current_optimizer_state;
    logic thermal_regulation_flag;
    logic data_line_detect_running;
    logic battery_undervoltage_release;
    logic blocking_pair_two_fitted;
    logic blocking_pair_one_fitted;
    logic conversion_done;
    logic oneshot_mode;
    logic forward_mode;
    logic sys_held_at_min;
    logic fast_charge_timer_expired;
    logic trickle_timer_expired;
    logic precharge_timer_expired;
    logic reverse_mode_hot_fault;
    logic reverse_mode_cold_fault;
  } chs_status_in_type;

  // Register selected by a bus address.
  typedef enum logic [1:0] {
    CHS_SEL_NONE = 2'b00,
    CHS_SEL_ONE = 2'b01,
    CHS_SEL_TWO = 2'b10,
    CHS_SEL_THREE = 2'b11
  } chs_sel_type;

  // Whole state of the bank.
  typedef struct packed {
    chs_status_in_type sync1;
    chs_status_in_type sync2;
    logic done_prev;
    logic [7:0] stat_one;
    logic [7:0] stat_two;
    logic [7:0] stat_three;
    logic [31:0] hrdata;
  } chs_state_type;

endpackage : chs_pkg
`default_nettype wire

// >>> dv/chs_status_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none

module chs_status_bank_tb;

  // One row: inputs from the charger core beside the three bytes they should give.
  typedef struct packed {
    logic [2:0] ph;
    logic [3:0] src;
    logic det;
    logic [1:0] opt;
    logic [2:0] f2;
    logic [6:0] f3;
    logic [7:0] e1;
    logic [7:0] e2;
    logic [7:0] e3;
  } chs_row_type;

  logic hclk;
  logic hresetn;
  logic clk_en;
  logic hsel;
  logic hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] v;
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic [7:0] status_three;
  wire logic hready;
  chs_pkg::chs_status_in_type st;
  chs_pkg::chs_status_in_type cur;
  chs_row_type rows [0:10];
  logic [3:0] rsv_src [0:4];
  int err_total;
  int checked;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  chs_status_bank DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .status_raw_in(st),
    .status_one(status_one), .status_two(status_two), .status_three(status_three));

  // Free-running bus clock of 50 ns.
  always #25 hclk = ~hclk;

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // Waits for an edge at which ready is high, with a bounded count.
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'h1) begin
      n++;
      if (n > 50) begin
        chk("hreadyout", 32'h0000_0001, {31'h0000_0000, hreadyout});
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  // One single word transfer; entered just after a rising edge.
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'h1;
    haddr <= addr;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : ahb

  // Lets a new status level pass the two input flops into the registers.
  task automatic settle;
    repeat (4) @(posedge hclk);
  endtask : settle

  // Reads all three registers over the bus and compares them and the copies.
  task automatic check_regs(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
    ahb(1'h0, 32'h0000_0070, 32'h0000_0000, v);
    chk("reg_one", {24'h00_0000, e1}, v);
    ahb(1'h0, 32'h0000_0074, 32'h0000_0000, v);
    chk("reg_two", {24'h00_0000, e2}, v);
    ahb(1'h0, 32'h0000_0078, 32'h0000_0000, v);
    chk("reg_three", {24'h00_0000, e3}, v);
    chk("out_one", {24'h00_0000, e1}, {24'h00_0000, status_one});
    chk("out_two", {24'h00_0000, e2}, {24'h00_0000, status_two});
    chk("out_three", {24'h00_0000, e3}, {24'h00_0000, status_three});
  endtask : check_regs

  // Turns a row into the status bundle from the charger core.
  function automatic chs_pkg::chs_status_in_type mk_st(input chs_row_type r);
    chs_pkg::chs_status_in_type s;
    s = '0;
    s.charge_phase = r.ph;
    s.input_source_type = r.src;
    s.port_detect_complete = r.det;
    s.current_optimizer_state = r.opt;
    {s.thermal_regulation_flag, s.data_line_detect_running, s.battery_undervoltage_release} = r.f2;
    {s.blocking_pair_two_fitted, s.blocking_pair_one_fitted, s.forward_mode, s.sys_held_at_min,
      s.fast_charge_timer_expired, s.trickle_timer_expired, s.precharge_timer_expired} = r.f3;
    return s;
  endfunction : mk_st

  // Main sequence: reset, table of legal codes, then the awkward cases.
  initial begin
    hclk = 1'h0;
    hresetn = 1'h0;
    clk_en = 1'h1;
    hsel = 1'h0;
    hwrite = 1'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'h0;
    hsize = 3'h2;
    st = '0;
    err_total = 0;
    checked = 0;
    rows[0] = '{3'h0, 4'h1, 1'h1, 2'h0, 3'h0, 7'h00, 8'h03, 8'h00, 8'h00};
    rows[1] = '{3'h1, 4'h2, 1'h0, 2'h1, 3'h4, 7'h40, 8'h24, 8'h44, 8'h80};
    rows[2] = '{3'h2, 4'h3, 1'h1, 2'h2, 3'h2, 7'h20, 8'h47, 8'h82, 8'h40};
    rows[3] = '{3'h3, 4'h4, 1'h0, 2'h0, 3'h1, 7'h18, 8'h68, 8'h01, 8'h10};
    rows[4] = '{3'h4, 4'h5, 1'h1, 2'h0, 3'h0, 7'h10, 8'h8B, 8'h00, 8'h00};
    rows[5] = '{3'h6, 4'h6, 1'h0, 2'h0, 3'h0, 7'h08, 8'hCC, 8'h00, 8'h00};
    rows[6] = '{3'h7, 4'h7, 1'h1, 2'h0, 3'h0, 7'h04, 8'hEF, 8'h00, 8'h08};
    rows[7] = '{3'h0, 4'h8, 1'h0, 2'h0, 3'h0, 7'h02, 8'h10, 8'h00, 8'h04};
    rows[8] = '{3'h0, 4'hB, 1'h0, 2'h0, 3'h0, 7'h01, 8'h16, 8'h00, 8'h02};
    rows[9] = '{3'h0, 4'hC, 1'h0, 2'h0, 3'h0, 7'h00, 8'h18, 8'h00, 8'h00};
    rows[10] = '{3'h0, 4'h0, 1'h0, 2'h0, 3'h0, 7'h7F, 8'h00, 8'h00, 8'hDE};
    rsv_src = '{4'h9, 4'hA, 4'hD, 4'hE, 4'hF};
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    check_regs(8'h00, 8'h00, 8'h00);
    for (int i = 0; i < 11; i++) begin
      st <= mk_st(rows[i]);
      settle();
      check_regs(rows[i].e1, rows[i].e2, rows[i].e3);
      // Bits of the third register are covered by the same rows, except completion bit 5, which no row sets.
      chk("row_three", {24'h00_0000, rows[i].e3}, {24'h00_0000, status_three});
    end
    // Reserved codes leave the fields as they were.
    st <= mk_st(rows[2]);
    settle();
    for (int i = 0; i < 5; i++) begin
      cur = mk_st(rows[2]);
      cur.charge_phase = 3'h5;
      cur.input_source_type = rsv_src[i];
      cur.current_optimizer_state = 2'h3;
      st <= cur;
      settle();
      check_regs(8'h47, 8'h82, 8'h40);
    end
    // Hot or cold fault blanks the source only in reverse-supply mode.
    for (int k = 0; k < 3; k++) begin
      cur = mk_st(rows[(k == 1) ? 2 : 6]);
      cur.reverse_mode_cold_fault = (k == 0);
      cur.reverse_mode_hot_fault = (k != 0);
      st <= cur;
      settle();
      check_regs((k == 1) ? 8'h47 : 8'hE1, (k == 1) ? 8'h82 : 8'h00, (k == 1) ? 8'h40 : 8'h08);
    end
    // Writes to a read-only register change nothing; an unmapped word reads zero.
    ahb(1'h1, 32'h0000_0074, 32'hFFFF_FFFF, v);
    ahb(1'h1, 32'h0000_0070, 32'hFFFF_FFFF, v);
    check_regs(8'hE1, 8'h00, 8'h08);
    ahb(1'h0, 32'h0000_007C, 32'h0000_0000, v);
    chk("unmapped", 32'h0000_0000, v);
    // Completion flag: set in one-shot mode, cleared by the read that reports it.
    cur = mk_st(rows[0]);
    cur.oneshot_mode = 1'h1;
    st <= cur;
    settle();
    cur.conversion_done = 1'h1;
    st <= cur;
    settle();
    ahb(1'h0, 32'h0000_0078, 32'h0000_0000, v);
    chk("done_set", 32'h0000_0020, v);
    ahb(1'h0, 32'h0000_0078, 32'h0000_0000, v);
    chk("done_clear", 32'h0000_0000, v);
    cur.oneshot_mode = 1'h0;
    cur.conversion_done = 1'h0;
    st <= cur;
    settle();
    cur.conversion_done = 1'h1;
    st <= cur;
    settle();
    ahb(1'h0, 32'h0000_0078, 32'h0000_0000, v);
    chk("done_no_oneshot", 32'h0000_0000, v);
    // A level shows after the third edge, not before.
    cur.thermal_regulation_flag = 1'h1;
    st <= cur;
    repeat (2) @(posedge hclk);
    #1;
    chk("treg_early", 32'h0000_0000, {31'h0000_0000, status_two[2]});
    @(posedge hclk);
    #1;
    chk("treg_on", 32'h0000_0001, {31'h0000_0000, status_two[2]});
    // A low clock enable freezes the registers and holds the bus ready low.
    @(posedge hclk);
    clk_en <= 1'h0;
    cur.battery_undervoltage_release = 1'h1;
    st <= cur;
    settle();
    chk("ready_frozen", 32'h0000_0000, {31'h0000_0000, hreadyout});
    chk("bat_frozen", 32'h0000_0004, {24'h00_0000, status_two});
    clk_en <= 1'h1;
    settle();
    chk("bat_on", 32'h0000_0005, {24'h00_0000, status_two});
    // A second reset in mid-run clears every register.
    @(posedge hclk);
    hresetn <= 1'h0;
    @(posedge hclk);
    #1;
    chk("rst_regs", 32'h0000_0000, {8'h00, status_one, status_two, status_three});
    chk("rst_rdata", 32'h0000_0000, hrdata);
    @(posedge hclk);
    hresetn <= 1'h1;
    // The first two edges after release only fill the input flops.
    repeat (2) @(posedge hclk);
    #1;
    chk("rst_edge2", 32'h0000_0000, {8'h00, status_one, status_two, status_three});
    @(posedge hclk);
    check_regs(8'h03, 8'h05, 8'h00);
    print_verdict();
  end

endmodule : chs_status_bank_tb

`default_nettype wire
